//--- edge_irq_pkg.sv
// Purpose: Shared constants and types of the external edge interrupt unit
// Assumes: APB slave, 32-bit data, register byte address = index * 4
// Notes: Pin index 0..7 is port 0, 8..11 is port 1 pins 0..3
`default_nettype none
package edge_irq_pkg;

    localparam int ADDR_W = 10;
    localparam int DATA_W = 32;
    localparam int NPIN = 12;
    localparam int NVEC = 5;

    // Register indices; byte address is the index times four
    localparam logic [7:0] IDX_P0_HIGH_SEL = 8'hCA;
    localparam logic [7:0] IDX_P0_LOW_SEL = 8'hCB;
    localparam logic [7:0] IDX_P1_SEL = 8'hCC;
    localparam logic [7:0] IDX_GROUP_FLAGS = 8'hCD;
    localparam logic [7:0] IDX_P0_PENDING = 8'hD7;
    localparam logic [7:0] IDX_P1_PENDING = 8'hD8;
    localparam logic [7:0] IDX_EVENT_STATUS = 8'hE0;
    localparam logic [7:0] IDX_EVENT_MASK = 8'hE1;

    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [11:0] RST_PINS = 12'h000;
    localparam logic [DATA_W-1:0] RD_ZERO = 32'h0000_0000;

    // Pin index of each line
    localparam int PIN_LINE0 = 2;
    localparam int PIN_LINE1 = 3;
    localparam int PIN_LINE2 = 4;
    localparam int PIN_LINE3 = 5;
    localparam int PIN_LINE4 = 6;
    localparam int PIN_LINE5 = 7;
    localparam int PIN_LINE6 = 8;
    localparam int PIN_LINE7 = 9;
    localparam int PIN_LINE8 = 10;
    localparam int PIN_LINE9 = 11;
    localparam int PIN_LINE10 = 0;
    localparam int PIN_LINE11 = 1;

    // Grouped pins sharing one vector
    localparam logic [11:0] GROUP_PINS = 12'hE57;

    // Vector request / acknowledge positions
    localparam int VEC_GROUP = 0;
    localparam int VEC_LINE6 = 1;
    localparam int VEC_LINE5 = 2;
    localparam int VEC_LINE3 = 3;
    localparam int VEC_LINE1 = 4;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_FALL = 2'b01,
        EDGE_RISE = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_mode_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

endpackage
`default_nettype wire

//--- external_edge_interrupt_unit.sv
// Purpose: Twelve edge-triggered external interrupt lines behind an APB slave
// Assumes: Pins synchronous enough to sample with a two-stage synchroniser
// Notes: One wait state on every APB access; pready and prdata are registered
//
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module external_edge_interrupt_unit (
    input wire logic clk,
    input wire logic rst_n,
    input wire edge_irq_pkg::apb_req_s apb_req,
    output logic [edge_irq_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port0_pins,
    input wire logic [3:0] port1_low_pins,
    input wire logic [edge_irq_pkg::NVEC-1:0] vector_ack,
    output logic [edge_irq_pkg::NVEC-1:0] vector_req,
    output logic irq
);
    import edge_irq_pkg::*;

    logic [7:0] p0_high_sel_reg;
    logic [7:0] p0_low_sel_reg;
    logic [7:0] p1_sel_reg;
    logic [7:0] group_flags_reg;
    logic [7:0] group_flags_next;
    logic [11:0] pending_reg;
    logic [11:0] pending_next;
    logic [11:0] status_reg;
    logic [11:0] status_next;
    logic [11:0] mask_reg;
    logic [11:0] sync1_reg;
    logic [11:0] sync2_reg;
    logic [11:0] prev_reg;
    logic [11:0] pins_in;
    logic [11:0] edge_hit;
    logic [11:0] ack_clear;
    logic [23:0] sel_all;
    logic [DATA_W-1:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [NVEC-1:0] vector_req_reg;
    logic irq_reg;
    logic access;
    logic wr_en;
    logic [7:0] wr_byte;
    logic [11:0] wr_pins;
    logic hit_p0_high;
    logic hit_p0_low;
    logic hit_p1_sel;
    logic hit_group;
    logic hit_p0_pend;
    logic hit_p1_pend;
    logic hit_status;
    logic hit_mask;
    logic setup_seen;
    logic rd_en;

    // Address decode: hit when byte address equals index times four
    function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
        addr_hit = (addr == {idx, 2'b00});
    endfunction

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        addr_mapped = addr_hit(addr, IDX_P0_HIGH_SEL) | addr_hit(addr, IDX_P0_LOW_SEL)
            | addr_hit(addr, IDX_P1_SEL) | addr_hit(addr, IDX_GROUP_FLAGS)
            | addr_hit(addr, IDX_P0_PENDING) | addr_hit(addr, IDX_P1_PENDING)
            | addr_hit(addr, IDX_EVENT_STATUS) | addr_hit(addr, IDX_EVENT_MASK);
    endfunction

    function automatic logic [7:0] group_of(input logic [11:0] p);
        group_of = {p[PIN_LINE0], p[PIN_LINE2], p[PIN_LINE4], p[PIN_LINE7],
                    p[PIN_LINE8], p[PIN_LINE9], p[PIN_LINE10], p[PIN_LINE11]};
    endfunction

    assign pins_in = {port1_low_pins, port0_pins};
    // field layout, pin i at bits 2i+1:2i
    assign sel_all = {p1_sel_reg, p0_high_sel_reg, p0_low_sel_reg};

    assign access = apb_req.psel & apb_req.penable & pready_reg;
    assign wr_en = access & apb_req.pwrite;
    assign wr_byte = apb_req.pwdata[7:0];
    assign wr_pins = apb_req.pwdata[11:0];

    // One decoded hit per register, shared by write and read paths
    assign hit_p0_high = addr_hit(apb_req.paddr, IDX_P0_HIGH_SEL);
    assign hit_p0_low = addr_hit(apb_req.paddr, IDX_P0_LOW_SEL);
    assign hit_p1_sel = addr_hit(apb_req.paddr, IDX_P1_SEL);
    assign hit_group = addr_hit(apb_req.paddr, IDX_GROUP_FLAGS);
    assign hit_p0_pend = addr_hit(apb_req.paddr, IDX_P0_PENDING);
    assign hit_p1_pend = addr_hit(apb_req.paddr, IDX_P1_PENDING);
    assign hit_status = addr_hit(apb_req.paddr, IDX_EVENT_STATUS);
    assign hit_mask = addr_hit(apb_req.paddr, IDX_EVENT_MASK);
    // First access-phase cycle, before the wait state ends
    assign setup_seen = apb_req.psel & apb_req.penable & ~pready_reg;
    assign rd_en = setup_seen & ~apb_req.pwrite;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= RST_PINS;
            sync2_reg <= RST_PINS;
            prev_reg <= RST_PINS;
        end else begin
            sync1_reg <= pins_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_edge
            logic rise;
            logic fall;
            assign rise = sync2_reg[gi] & ~prev_reg[gi];
            assign fall = ~sync2_reg[gi] & prev_reg[gi];
            always_comb begin
                case (edge_mode_e'(sel_all[2*gi +: 2]))
                    EDGE_FALL: edge_hit[gi] = fall;
                    EDGE_RISE: edge_hit[gi] = rise;
                    EDGE_BOTH: edge_hit[gi] = rise | fall;
                    default: edge_hit[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_comb begin
        ack_clear = 12'h000;
        ack_clear[PIN_LINE6] = vector_ack[VEC_LINE6];
        ack_clear[PIN_LINE5] = vector_ack[VEC_LINE5];
        ack_clear[PIN_LINE3] = vector_ack[VEC_LINE3];
        ack_clear[PIN_LINE1] = vector_ack[VEC_LINE1];
        if (vector_ack[VEC_GROUP]) begin
            ack_clear = ack_clear | GROUP_PINS;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_high_sel_reg <= RST_BYTE;
        end else if (wr_en && hit_p0_high) begin
            p0_high_sel_reg <= wr_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_low_sel_reg <= RST_BYTE;
        end else if (wr_en && hit_p0_low) begin
            p0_low_sel_reg <= wr_byte;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_sel_reg <= RST_BYTE;
        end else if (wr_en && hit_p1_sel) begin
            p1_sel_reg <= wr_byte;
        end
    end

    // pending bits, set wins over write and acknowledge
    always_comb begin
        pending_next = pending_reg;
        if (wr_en && hit_p0_pend) begin
            pending_next[7:0] = wr_byte;
        end
        if (wr_en && hit_p1_pend) begin
            pending_next[11:8] = wr_byte[3:0];
        end
        pending_next = (pending_next & ~ack_clear) | edge_hit;
    end

    always_comb begin
        group_flags_next = group_flags_reg;
        if (wr_en && hit_group) begin
            group_flags_next = wr_byte;
        end
        group_flags_next = group_flags_next | group_of(edge_hit);
    end

    // Event status: write one to clear, set wins
    always_comb begin
        status_next = status_reg;
        if (wr_en && hit_status) begin
            status_next = status_reg & ~wr_pins;
        end
        status_next = status_next | edge_hit;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pending_reg <= RST_PINS;
        end else begin
            pending_reg <= pending_next;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            group_flags_reg <= RST_BYTE;
        end else begin
            group_flags_reg <= group_flags_next;
        end
    end

    // Sticky event status register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= RST_PINS;
        end else begin
            status_reg <= status_next;
        end
    end

    // Event mask register, one enables the line
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= RST_PINS;
        end else if (wr_en && hit_mask) begin
            mask_reg <= wr_pins;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            vector_req_reg <= '0;
        end else begin
            vector_req_reg[VEC_GROUP] <= |(pending_next & GROUP_PINS);
            vector_req_reg[VEC_LINE6] <= pending_next[PIN_LINE6];
            vector_req_reg[VEC_LINE5] <= pending_next[PIN_LINE5];
            vector_req_reg[VEC_LINE3] <= pending_next[PIN_LINE3];
            vector_req_reg[VEC_LINE1] <= pending_next[PIN_LINE1];
        end
    end

    // Level interrupt while an unmasked status bit is set
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_next & mask_reg);
        end
    end

    // APB answer: exactly one wait state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready_reg <= 1'b0;
        end else begin
            pready_reg <= setup_seen;
        end
    end

    // Unmapped address answered with an error
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pslverr_reg <= 1'b0;
        end else begin
            pslverr_reg <= setup_seen & ~addr_mapped(apb_req.paddr);
        end
    end

    // Registered read data, zero outside a read answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_reg <= RD_ZERO;
        end else begin
            prdata_reg <= RD_ZERO;
            if (rd_en) begin
                if (hit_p0_high) begin
                    prdata_reg[7:0] <= p0_high_sel_reg;
                end
                if (hit_p0_low) begin
                    prdata_reg[7:0] <= p0_low_sel_reg;
                end
                if (hit_p1_sel) begin
                    prdata_reg[7:0] <= p1_sel_reg;
                end
                if (hit_group) begin
                    prdata_reg[7:0] <= group_flags_reg;
                end
                if (hit_p0_pend) begin
                    prdata_reg[7:0] <= pending_reg[7:0];
                end
                if (hit_p1_pend) begin
                    prdata_reg[3:0] <= pending_reg[11:8];
                end
                if (hit_status) begin
                    prdata_reg[11:0] <= status_reg;
                end
                if (hit_mask) begin
                    prdata_reg[11:0] <= mask_reg;
                end
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign vector_req = vector_req_reg;
    assign irq = irq_reg;

endmodule // external_edge_interrupt_unit
`default_nettype wire

//--- edge_irq_chk.sv
// Purpose: Port-level checks of the external edge interrupt unit
// Assumes: Two-stage pin synchroniser, one APB wait state
// Notes: Quiet and idle counters gate the stability checks
`timescale 1ns/1ps
`default_nettype none
module edge_irq_chk (
    input wire logic clk,
    input wire logic rst_n,
    input wire edge_irq_pkg::apb_req_s apb_req,
    input wire logic [edge_irq_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] port0_pins,
    input wire logic [3:0] port1_low_pins,
    input wire logic [edge_irq_pkg::NVEC-1:0] vector_ack,
    input wire logic [edge_irq_pkg::NVEC-1:0] vector_req,
    input wire logic irq
);
    import edge_irq_pkg::*;
    logic [11:0] prev;
    logic [2:0] qc;
    logic [2:0] ic;
    // Cycles with unchanged pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 12'h000;
            qc <= 3'h0;
        end else begin
            prev <= {port1_low_pins, port0_pins};
            if ({port1_low_pins, port0_pins} != prev) qc <= 3'h0;
            else if (qc != 3'h7) qc <= qc + 3'h1;
        end
    end
    // Cycles without bus or acknowledge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) ic <= 3'h0;
        else if (apb_req.psel || (|vector_ack)) ic <= 3'h0;
        else if (ic != 3'h7) ic <= ic + 3'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_wait; apb_req.psel && apb_req.penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait)
        else $error("pready missing after access");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse)
        else $error("pready longer than one cycle");
    property p_err; pslverr |-> pready && apb_req.psel && apb_req.penable; endproperty
    a_err: assert property (p_err)
        else $error("pslverr outside access");
    property p_err_zero; pslverr && !apb_req.pwrite |-> prdata == '0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read not zero");
    property p_quiet; qc >= 3'h6 && ic >= 3'h3 |-> $stable(vector_req) && $stable(irq); endproperty
    a_quiet: assert property (p_quiet)
        else $error("request changed on steady pins");
    property p_rise; $rose(vector_req[VEC_GROUP]) |-> qc < 3'h6 || ic < 3'h3; endproperty
    a_rise: assert property (p_rise)
        else $error("group request without cause");
    property p_ack_grp;
        vector_ack[VEC_GROUP] && qc >= 3'h6 && !apb_req.psel |=> ##1 !vector_req[VEC_GROUP];
    endproperty
    a_ack_grp: assert property (p_ack_grp)
        else $error("group request kept after ack");
    property p_ack6;
        vector_ack[VEC_LINE6] && qc >= 3'h6 && !apb_req.psel |=> ##1 !vector_req[VEC_LINE6];
    endproperty
    a_ack6: assert property (p_ack6)
        else $error("line six request kept after ack");
endmodule // edge_irq_chk
bind external_edge_interrupt_unit edge_irq_chk edge_irq_chk_i (.clk(clk), .rst_n(rst_n), .apb_req(apb_req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pins(port0_pins),
    .port1_low_pins(port1_low_pins), .vector_ack(vector_ack), .vector_req(vector_req), .irq(irq));
`default_nettype wire

//--- edge_pin_source.sv
// Purpose: Far-side source of the external interrupt pin levels
// Assumes: Levels change just after a rising edge
// Notes: A level holds until the next call
`timescale 1ns/1ps
`default_nettype none
module edge_pin_source (
    input wire logic clk,
    output logic [7:0] port0_pins,
    output logic [3:0] port1_low_pins
);
    initial {port1_low_pins, port0_pins} = 12'h000;
    task automatic set(input logic [11:0] v);
        @(posedge clk);
        {port1_low_pins, port0_pins} <= v;
    endtask
endmodule // edge_pin_source
`default_nettype wire

//--- tb_top.sv
// Purpose: Register and pin tests of the external edge interrupt unit
// Assumes: APB master tasks, pin source model
// Notes: Expected values built from field layouts
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import edge_irq_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    apb_req_s req = '0;
    logic [31:0] prdata;
    logic [31:0] q;
    logic pready;
    logic pslverr;
    logic e;
    logic irq;
    logic [7:0] p0;
    logic [3:0] p1;
    logic [4:0] ack = 5'h0;
    logic [4:0] vreq;
    logic [7:0] regs [8];
    int num_errors = 0;
    int tests_run = 0;
    int m;
    always #10 clk = ~clk;
    external_edge_interrupt_unit external_edge_interrupt_unit_i (.clk(clk), .rst_n(rst_n), .apb_req(req),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .port0_pins(p0), .port1_low_pins(p1),
        .vector_ack(ack), .vector_req(vreq), .irq(irq));
    edge_pin_source edge_pin_source_i (.clk(clk), .port0_pins(p0), .port1_low_pins(p1));
    task automatic conclude;
        if (num_errors == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        tests_run++;
        if (g !== x) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, x);
            num_errors++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] i, input logic [31:0] d);
        int n;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, {i, 2'b00}, d};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
    endtask
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        xfer(1'b1, i, d);
    endtask
    task automatic rd(input logic [7:0] i, input logic [31:0] x);
        xfer(1'b0, i, 32'h0);
        chk(q, x);
    endtask
    task automatic pin(input logic [11:0] v);
        edge_pin_source_i.set(v);
        repeat (6) @(posedge clk);
    endtask
    task automatic pulse(input logic [4:0] v);
        @(posedge clk);
        ack <= v;
        @(posedge clk);
        ack <= 5'h0;
        repeat (2) @(posedge clk);
    endtask
    initial begin
        regs = '{IDX_P0_HIGH_SEL, IDX_P0_LOW_SEL, IDX_P1_SEL, IDX_GROUP_FLAGS,
                 IDX_P0_PENDING, IDX_P1_PENDING, IDX_EVENT_STATUS, IDX_EVENT_MASK};
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        wr(8'h10, 32'hFF);
        rd(8'h10, 32'h0);
        chk({31'h0, e}, 32'h1);
        foreach (regs[k]) rd(regs[k], 32'h0);
        wr(IDX_P1_PENDING, 32'hFF);
        rd(IDX_P1_PENDING, 32'h0F);
        wr(IDX_P1_PENDING, 32'h0);
        for (m = 0; m < 4; m++) begin
            wr(IDX_P0_HIGH_SEL, 32'(m << 6));
            pin(12'h080);
            chk({27'h0, vreq}, {29'h0, m[1], 2'h0});
            rd(IDX_P0_PENDING, {24'h0, m[1], 7'h0});
            wr(IDX_P0_PENDING, 32'h0);
            pin(12'h000);
            rd(IDX_P0_PENDING, {24'h0, m[0], 7'h0});
            wr(IDX_P0_PENDING, 32'h0);
        end
        rd(IDX_GROUP_FLAGS, 32'h0);
        wr(IDX_P0_LOW_SEL, 32'h30);
        pin(12'h004);
        rd(IDX_P0_PENDING, 32'h04);
        rd(IDX_GROUP_FLAGS, 32'h80);
        chk({27'h0, vreq}, 32'h01);
        pulse(5'h01);
        rd(IDX_P0_PENDING, 32'h0);
        rd(IDX_GROUP_FLAGS, 32'h80);
        chk({27'h0, vreq}, 32'h0);
        wr(IDX_GROUP_FLAGS, 32'h0);
        pin(12'h000);
        rd(IDX_P0_PENDING, 32'h04);
        rd(IDX_GROUP_FLAGS, 32'h80);
        wr(IDX_P0_PENDING, 32'h0);
        wr(IDX_GROUP_FLAGS, 32'h0);
        wr(IDX_EVENT_STATUS, 32'hFFF);
        rd(IDX_EVENT_STATUS, 32'h0);
        wr(IDX_P1_SEL, 32'h82);
        pin(12'h900);
        rd(IDX_P1_PENDING, 32'h09);
        rd(IDX_GROUP_FLAGS, 32'h04);
        chk({27'h0, vreq}, 32'h03);
        pulse(5'h02);
        rd(IDX_P1_PENDING, 32'h08);
        rd(IDX_EVENT_STATUS, 32'h900);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_EVENT_MASK, 32'h800);
        rd(IDX_EVENT_MASK, 32'h800);
        chk({31'h0, irq}, 32'h1);
        wr(IDX_EVENT_STATUS, 32'h800);
        rd(IDX_EVENT_STATUS, 32'h100);
        chk({31'h0, irq}, 32'h0);
        wr(IDX_P1_PENDING, 32'h0);
        wr(IDX_P0_HIGH_SEL, 32'h08);
        wr(IDX_P0_LOW_SEL, 32'h80);
        pin(12'h928);
        rd(IDX_P0_PENDING, 32'h28);
        chk({27'h0, vreq}, 32'h18);
        pulse(5'h18);
        rd(IDX_P0_PENDING, 32'h0);
        chk({27'h0, vreq}, 32'h0);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
